/* File: rtl/pmt_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  period match timer.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH

`define PMT_OFF_COUNT      12'h000
`define PMT_OFF_PERIOD     12'h004
`define PMT_OFF_CONTROL    12'h008
`define PMT_OFF_IRQ_STATUS 12'h00c
`define PMT_OFF_IRQ_MASK   12'h010

`define PMT_COUNT_RST      8'h00
`define PMT_PERIOD_RST     8'hff
`define PMT_CONTROL_RST    7'h00

`define PMT_CTL_PRE_LSB    0
`define PMT_CTL_ON_BIT     2
`define PMT_CTL_POST_LSB   3

`define PMT_IRQ_MATCH_BIT  0

`define PMT_CYCLES_PER_INSTR 4

`endif

/* File: rtl/pmt_pkg.sv */
/*
  Types shared by the period match timer.
  Assumes the constants header is included alongside.
*/
package pmt_pkg;

  typedef enum logic [1:0] {
    PMT_PRE_1  = 2'h0,
    PMT_PRE_4  = 2'h1,
    PMT_PRE_16 = 2'h2,
    PMT_PRE_64 = 2'h3
  } pmt_prescale_t;

  typedef struct packed {
    logic [3:0]    postscale_select;
    logic          timer_on;
    pmt_prescale_t prescale_select;
  } pmt_control_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmt_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pmt_apb_rsp_t;

endpackage

/* File: rtl/pmt_timer.sv */
/*
  Period match timer: 8-bit up counter on the instruction clock with
  prescaler, period compare, 4-bit postscaler and sticky match interrupt.
  Assumes one clock domain, APB register access, and a synchronous sleep
  input from the core.
*/
`timescale 1ns/1ps
`include "pmt_regs.svh"

// What this block does
// - The count clock is the instruction clock, system clock divided by four.
// - The count starts at zero and steps by one per prescaled edge when on.
// - On each prescaled edge the count is compared with the period and on equality a match pulses.
// - After a match the count goes to zero and the postscaler advances.
// - Software may read and write count and period at any time.
// - Reset clears the count and loads the period with all ones.
// - Writes to count or control and any reset clear pre- and postscaler.
// - A control write leaves the count value unchanged.
// - Matches clock a 4-bit postscaler whose expiry sets a sticky flag.
// - The flag raises the interrupt only while its enable bit is set.
// - The postscale ratio is the select code plus one, 1:1 to 1:16.
// - The on bit starts the timer when set and stops it when clear.
// - The unscaled match pulse goes to the PWM unit and the SPI port.
// - In sleep the timer does not count and keeps count and period.
module pmt_timer #(
  parameter int PRE_W = 6
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // APB slave
  input  wire pmt_pkg::pmt_apb_req_t apb_req,
  output      pmt_pkg::pmt_apb_rsp_t apb_rsp,
  // Core
  input  wire logic                  sleep,
  // Match outputs
  output      logic                  pwm_time_base,
  output      logic                  spi_shift_clock,
  output      logic                  irq
);

  typedef enum logic [1:0] {
    PMT_ST_IDLE  = 2'b00,
    PMT_ST_SETUP = 2'b01,
    PMT_ST_DONE  = 2'b11
  } pmt_state_t;

  // Bus phase
  pmt_state_t            state;
  pmt_state_t            next_state;

  // Software-visible registers
  pmt_pkg::pmt_control_t timer_control;
  logic [7:0]            tick_count;
  logic [7:0]            period_value;

  // Dividers
  logic [1:0]            instr_div;
  logic [PRE_W-1:0]      prescale_cnt;
  logic [3:0]            postscale_cnt;

  // Interrupt
  logic                  match_flag;
  logic                  match_irq_enable;

  // Strobes and decode
  logic                  match_pulse;
  logic                  wr_en;
  logic                  wr_count;
  logic                  wr_period;
  logic                  wr_control;
  logic                  wr_status;
  logic                  wr_mask;
  logic                  mapped;
  logic                  instr_tick;
  logic                  pre_tick;
  logic                  post_expire;
  logic [31:0]           next_rdata;

  // Register map, one register of at most 8 bits per aligned 32-bit word:
  //   count      bits 7:0, running value, writes restart both scalers
  //   period     bits 7:0, terminal value of the count
  //   control    bits 6:3 postscale, bit 2 on, bits 1:0 prescale
  //   status     bit 0 match flag, write one to clear
  //   mask       bit 0 match interrupt enable
  // Upper bits read as zero and ignore writes. Any other offset answers
  // with pslverr, reads zero and drops the write.
  //
  // Timing in mclk cycles:
  //   one instruction tick every four cycles, paused while asleep
  //   one count step every 1, 4, 16 or 64 instruction ticks
  //   period P gives P + 1 steps from one match to the next
  //   postscale code N gives N + 1 matches per flag
  //
  // Hazard: a count or control write in the cycle of a prescaled tick swallows
  // that tick, so software never sees a half-updated count.

  // Prescale code to terminal count of the divider
  function automatic logic [PRE_W-1:0] pre_last(pmt_pkg::pmt_prescale_t s);
    case (s)
      pmt_pkg::PMT_PRE_1:  pre_last = PRE_W'(0);
      pmt_pkg::PMT_PRE_4:  pre_last = PRE_W'(3);
      pmt_pkg::PMT_PRE_16: pre_last = PRE_W'(15);
      pmt_pkg::PMT_PRE_64: pre_last = PRE_W'(63);
      default:             pre_last = PRE_W'(0);
    endcase
  endfunction

  function automatic logic addr_is(logic [11:0] a, logic [11:0] off);
    addr_is = (a == off);
  endfunction

  // APB: setup -> access, answer with pready in the access cycle
  always_comb begin
    next_state = state;
    case (state)
      PMT_ST_IDLE: begin
        if (apb_req.psel) begin
          next_state = PMT_ST_SETUP;
        end else begin
          next_state = PMT_ST_IDLE;
        end
      end
      PMT_ST_SETUP: begin
        if (apb_req.penable) begin
          next_state = PMT_ST_DONE;
        end else begin
          next_state = PMT_ST_SETUP;
        end
      end
      PMT_ST_DONE: begin
        if (apb_req.psel) begin
          next_state = PMT_ST_SETUP;
        end else begin
          next_state = PMT_ST_IDLE;
        end
      end
      default: begin
        next_state = PMT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= PMT_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign mapped     = addr_is(apb_req.paddr, `PMT_OFF_COUNT) ||
                      addr_is(apb_req.paddr, `PMT_OFF_PERIOD) ||
                      addr_is(apb_req.paddr, `PMT_OFF_CONTROL) ||
                      addr_is(apb_req.paddr, `PMT_OFF_IRQ_STATUS) ||
                      addr_is(apb_req.paddr, `PMT_OFF_IRQ_MASK);
  assign wr_en      = apb_req.psel && apb_req.penable && apb_req.pwrite;

  // One strobe per register, only in the access cycle of a write
  always_comb begin
    wr_count   = 1'b0;
    wr_period  = 1'b0;
    wr_control = 1'b0;
    wr_status  = 1'b0;
    wr_mask    = 1'b0;
    if (wr_en) begin
      case (apb_req.paddr)
        `PMT_OFF_COUNT: begin
          wr_count = 1'b1;
        end
        `PMT_OFF_PERIOD: begin
          wr_period = 1'b1;
        end
        `PMT_OFF_CONTROL: begin
          wr_control = 1'b1;
        end
        `PMT_OFF_IRQ_STATUS: begin
          wr_status = 1'b1;
        end
        `PMT_OFF_IRQ_MASK: begin
          wr_mask = 1'b1;
        end
        default: begin
          wr_count = 1'b0;
        end
      endcase
    end
  end

  // Zero-wait slave; unmapped addresses answer with pslverr
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (apb_req.paddr)
      `PMT_OFF_COUNT: begin
        next_rdata = {24'h00_0000, tick_count};
      end
      `PMT_OFF_PERIOD: begin
        next_rdata = {24'h00_0000, period_value};
      end
      `PMT_OFF_CONTROL: begin
        next_rdata = {25'h000_0000, timer_control};
      end
      `PMT_OFF_IRQ_STATUS: begin
        next_rdata = {31'h0000_0000, match_flag};
      end
      `PMT_OFF_IRQ_MASK: begin
        next_rdata = {31'h0000_0000, match_irq_enable};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered in the setup cycle, valid in the access cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      apb_rsp.prdata <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      apb_rsp.prdata <= next_rdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_control <= `PMT_CONTROL_RST;
    end else if (wr_control) begin
      timer_control <= apb_req.pwdata[6:0];
    end
  end

  // Fosc/4 instruction clock as a one-in-four enable; frozen in sleep
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      instr_div <= 2'h0;
    end else if (!sleep) begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // Gated by sleep as well, so the cycle that enters sleep cannot
  // still step the count on a tick already decoded
  assign instr_tick = !sleep && (instr_div == 2'(`PMT_CYCLES_PER_INSTR - 1));

  // Prescaler runs only while on; cleared by count or control writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_cnt <= '0;
    end else if (wr_count || wr_control) begin
      prescale_cnt <= '0;
    end else if (instr_tick && timer_control.timer_on) begin
      if (pre_tick) begin
        prescale_cnt <= '0;
      end else begin
        prescale_cnt <= prescale_cnt + PRE_W'(1);
      end
    end
  end

  assign pre_tick = instr_tick && timer_control.timer_on &&
                    (prescale_cnt == pre_last(timer_control.prescale_select));

  // Count: match decoded combinationally on the prescaled edge, restart at zero on that same edge
  assign match_pulse = pre_tick && !wr_count && !wr_control &&
                       (tick_count == period_value);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_count <= `PMT_COUNT_RST;
    end else if (wr_count) begin
      tick_count <= apb_req.pwdata[7:0];
    end else if (match_pulse) begin
      tick_count <= 8'h00;
    end else if (pre_tick && !wr_control) begin
      tick_count <= tick_count + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      period_value <= `PMT_PERIOD_RST;
    end else if (wr_period) begin
      period_value <= apb_req.pwdata[7:0];
    end
  end

  // Unscaled match to PWM time base and SPI shift clock;
  // combinational, so consumers sample it at the next rising edge
  assign pwm_time_base   = match_pulse;
  assign spi_shift_clock = match_pulse;

  // Select code compared directly, so a ratio change takes effect
  // after the scaler is cleared by the control write itself
  assign post_expire = match_pulse &&
                       (postscale_cnt == timer_control.postscale_select);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      postscale_cnt <= 4'h0;
    end else if (wr_count || wr_control) begin
      postscale_cnt <= 4'h0;
    end else if (post_expire) begin
      postscale_cnt <= 4'h0;
    end else if (match_pulse) begin
      postscale_cnt <= postscale_cnt + 4'h1;
    end
  end

  // Sticky flag: a new expiry wins over a write-one clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      match_flag <= 1'b0;
    end else if (post_expire) begin
      match_flag <= 1'b1;
    end else if (wr_status && apb_req.pwdata[`PMT_IRQ_MATCH_BIT]) begin
      match_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      match_irq_enable <= 1'b0;
    end else if (wr_mask) begin
      match_irq_enable <= apb_req.pwdata[`PMT_IRQ_MATCH_BIT];
    end
  end

  // Level output; the flag stays latched while masked, so enabling
  // the mask later raises a pending request at once
  assign irq = match_flag && match_irq_enable;

endmodule

/* File: verification/pmt_timer_sva.sv */
/*
  Port checker for the period match timer.
  Assumes it is bound to pmt_timer and sees only its ports.
*/
`timescale 1ns/1ps
module pmt_chk (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  arst_n,
  // Bus and core
  input wire pmt_pkg::pmt_apb_req_t apb_req,
  input wire pmt_pkg::pmt_apb_rsp_t apb_rsp,
  input wire logic                  sleep,
  // Outputs
  input wire logic                  pwm_time_base,
  input wire logic                  spi_shift_clock,
  input wire logic                  irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic wr;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  AST_READY: assert property (apb_rsp.pready)
    else $error("pready low");
  AST_SPI: assert property (spi_shift_clock == pwm_time_base)
    else $error("shift clock differs");
  AST_GAP: assert property (pwm_time_base |=> !pwm_time_base [*3])
    else $error("match pulses too close");
  AST_SLEEP: assert property (sleep && $past(sleep) |-> !pwm_time_base)
    else $error("match in sleep");
  AST_STICKY: assert property (irq && !wr |=> irq)
    else $error("flag lost");
  AST_MASK: assert property (wr && apb_req.paddr == 12'h010
    && !apb_req.pwdata[0] |=> !irq) else $error("masked irq high");
  AST_ERR: assert property (apb_req.psel && apb_req.penable
    && apb_req.paddr > 12'h010 |-> apb_rsp.pslverr) else $error("no slverr");
  AST_OFF: assert property (wr && apb_req.paddr == 12'h008
    && !apb_req.pwdata[2] |=> !pwm_time_base [*8]) else $error("off pulse");
  AST_RST: assert property ($rose(arst_n) |-> !irq && !pwm_time_base)
    else $error("outputs after reset");
endmodule

bind pmt_timer pmt_chk u_chk (.mclk(mclk), .arst_n(arst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .sleep(sleep),
  .pwm_time_base(pwm_time_base), .spi_shift_clock(spi_shift_clock),
  .irq(irq));

/* File: verification/pmt_timer_tb.sv */
/*
  Self-checking bench for the period match timer.
  Assumes zero-wait APB slave and the offsets of the register header.
*/
`timescale 1ns/1ps
`include "pmt_regs.svh"
module pmt_timer_tb;
  logic                  mclk   = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  sleep  = 1'b0;
  pmt_pkg::pmt_apb_req_t req    = '0;
  pmt_pkg::pmt_apb_rsp_t rsp;
  logic                  pwm, spi, irq, err;
  logic [31:0]           rd;
  int                    miscompares = 0;
  int                    n_compared  = 0;
  int                    n, q, p, per;

  pmt_timer u_dut (.mclk(mclk), .arst_n(arst_n), .apb_req(req),
    .apb_rsp(rsp), .sleep(sleep), .pwm_time_base(pwm),
    .spi_shift_clock(spi), .irq(irq));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s exp %h seen %h", s, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task rdchk(input string s, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(s, rd, exp);
  endtask

  // Edges until the next match pulse, sampled after updates land
  task wait_pulse(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (pwm !== 1'b1 && c < 9000);
  endtask

  function automatic int gap(int pre, int prd);
    return (prd + 1) * 4 * (1 << (2 * pre));
  endfunction

  task give_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    give_verdict;
  end

  initial begin
    void'($urandom(96398));
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    rdchk("count", `PMT_OFF_COUNT, 32'h0);
    rdchk("period", `PMT_OFF_PERIOD, 32'hff);
    rdchk("control", `PMT_OFF_CONTROL, 32'h0);
    rdchk("unmapped", 12'h020, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, `PMT_OFF_CONTROL, 32'hff);
    rdchk("ctl top", `PMT_OFF_CONTROL, 32'h7f);
    per = $urandom % 256;
    apb(1'b1, `PMT_OFF_PERIOD, 32'(per));
    rdchk("period rw", `PMT_OFF_PERIOD, 32'(per));
    $display("test regs done");
    for (p = 0; p < 4; p++) begin
      per = (p == 1) ? 255 : $urandom % 8;
      apb(1'b1, `PMT_OFF_CONTROL, 32'h0);
      apb(1'b1, `PMT_OFF_COUNT, 32'h0);
      apb(1'b1, `PMT_OFF_PERIOD, 32'(per));
      apb(1'b1, `PMT_OFF_CONTROL, 32'(4 + p));
      wait_pulse(n);
      wait_pulse(n);
      chk("shift clock", {31'h0, spi}, 32'h1);
      chk("match gap", n, gap(p, per));
    end
    $display("test gap done");
    apb(1'b1, `PMT_OFF_IRQ_MASK, 32'h1);
    for (p = 0; p < 4; p++) begin
      q = (p < 2) ? p * 15 : $urandom % 16;
      apb(1'b1, `PMT_OFF_CONTROL, 32'h0);
      apb(1'b1, `PMT_OFF_PERIOD, 32'h1);
      apb(1'b1, `PMT_OFF_IRQ_STATUS, 32'h1);
      apb(1'b1, `PMT_OFF_CONTROL, 32'(q * 8 + 4));
      n = 0;
      for (int k = 0; k < 3000 && irq !== 1'b1; k++) begin
        @(posedge mclk);
        #1;
        if (pwm === 1'b1) n++;
      end
      chk("post ratio", n, q + 1);
    end
    apb(1'b1, `PMT_OFF_IRQ_MASK, 32'h0);
    rdchk("status", `PMT_OFF_IRQ_STATUS, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `PMT_OFF_CONTROL, 32'h0);
    apb(1'b1, `PMT_OFF_IRQ_STATUS, 32'h1);
    rdchk("status clr", `PMT_OFF_IRQ_STATUS, 32'h0);
    $display("test post done");
    apb(1'b1, `PMT_OFF_COUNT, 32'h5a);
    repeat (20) @(posedge mclk);
    apb(1'b1, `PMT_OFF_CONTROL, 32'h1a);
    rdchk("count kept", `PMT_OFF_COUNT, 32'h5a);
    $display("test hold done");
    apb(1'b1, `PMT_OFF_PERIOD, 32'hff);
    apb(1'b1, `PMT_OFF_CONTROL, 32'h4);
    sleep <= 1'b1;
    apb(1'b0, `PMT_OFF_COUNT, 32'h0);
    n = rd;
    repeat (40) @(posedge mclk);
    rdchk("sleep hold", `PMT_OFF_COUNT, 32'(n));
    rdchk("sleep period", `PMT_OFF_PERIOD, 32'hff);
    sleep <= 1'b0;
    $display("test sleep done");
    give_verdict;
  end
endmodule
